// [logic/tws_regs.svh]
/*
 * Register map, bit positions, status codes and timing counts of the
 * two-wire master transmit and receive sequencer.
 * Assumes a 100 MHz system clock and a byte-wide register port.
 */
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH

// Register indices on the byte-wide port
`define TWS_ADDR_CONTROL 2'h0
`define TWS_ADDR_STATUS 2'h1
`define TWS_ADDR_BYTE 2'h2

// Control register bit positions
`define TWS_C_FLAG 7
`define TWS_C_ACK 6
`define TWS_C_START 5
`define TWS_C_STOP 4
`define TWS_C_WCOL 3
`define TWS_C_EN 2
`define TWS_C_IE 0

// Status register: code in the upper five bits, prescaler in the lowest two
`define TWS_S_CODE_HI 7
`define TWS_S_CODE_LO 3
`define TWS_S_PRESC_HI 1
`define TWS_S_PRESC_LO 0

// Status codes (prescaler bits zero)
`define TWS_CODE_START 8'h08
`define TWS_CODE_RSTART 8'h10
`define TWS_CODE_AW_ACK 8'h18
`define TWS_CODE_AW_NACK 8'h20
`define TWS_CODE_D_ACK 8'h28
`define TWS_CODE_D_NACK 8'h30
`define TWS_CODE_LOST 8'h38
`define TWS_CODE_AR_ACK 8'h40
`define TWS_CODE_AR_NACK 8'h48
`define TWS_CODE_RD_ACK 8'h50
`define TWS_CODE_RD_NACK 8'h58
`define TWS_CODE_IDLE 8'hf8

// Timing: one bit on the line is four quarter periods
`define TWS_CLK_NS 10
`define TWS_BIT_NS 10000
`define TWS_QTR_CYC ((`TWS_BIT_NS / 4) / `TWS_CLK_NS)
`define TWS_LAST_BIT 4'h8

`endif

// [logic/tws_pkg.sv]
/*
 * Types shared by the two-wire master transmit and receive sequencer.
 * Assumes the constants header is included by each module using it.
 */
package tws_pkg;

    typedef logic [1:0] tws_addr_t;
    typedef logic [7:0] tws_byte_t;

    typedef enum logic [2:0]
    {
        TWS_IDLE,
        TWS_WAIT_FREE,
        TWS_START,
        TWS_RSTART,
        TWS_BIT,
        TWS_HOLD,
        TWS_STOP
    } tws_state_t;

endpackage : tws_pkg

// [logic/tws_sync.sv]
/*
 * Two-stage synchroniser for one line sampled from outside the clock.
 * Assumes the input is a level; the output is safe for any logic.
 */
`timescale 1ns/10ps
module tws_sync
#(
    parameter logic RESET_VAL = 1'b1
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Line
    input wire logic din,
    output logic dout
);
    logic meta_r;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_r <= RESET_VAL;
            dout <= RESET_VAL;
        end
        else
        begin
            meta_r <= din;
            dout <= meta_r;
        end
    end

endmodule : tws_sync

// [logic/tws_master.sv]
/*
 * Two-wire bus master sequencer: START, repeated START, STOP, address
 * and data bytes, with status codes and a completion flag that holds
 * the bus (clock held low) until software clears it.
 * Assumes open-drain pads outside: an enable high pulls the line low.
 * Slave roles are not built; on lost arbitration the block only idles.
 */
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "tws_regs.svh"
module tws_master
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register port
    input wire tws_pkg::tws_addr_t reg_addr,
    input wire tws_pkg::tws_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output tws_pkg::tws_byte_t reg_rdata,
    // Serial clock line
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    // Serial data line
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Interrupt request
    output logic irq
);
    import tws_pkg::*;

    tws_state_t state_r;
    logic [1:0] phase_r;
    logic [3:0] bitcnt_r;
    logic [8:0] qcnt_r;
    logic tick;
    logic adv;
    logic scl_s;
    logic sda_s;
    logic sda_d_r;
    logic busy_r;
    logic flag_r;
    logic ack_en_r;
    logic start_r;
    logic stop_r;
    logic wcol_r;
    logic en_r;
    logic ie_r;
    logic [1:0] presc_r;
    tws_byte_t code_r;
    tws_byte_t byte_r;
    tws_byte_t sh_r;
    logic master_r;
    logic addr_next_r;
    logic rx_mode_r;
    logic dir_r;
    logic ack_seen_r;
    logic rx_load_r;
    logic ctrl_wr;
    logic flag_clr;
    logic go;
    logic tx_bit;

    tws_sync u_scl_sync
    (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .din(scl_in),
        .dout(scl_s)
    );

    tws_sync u_sda_sync
    (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .din(sda_in),
        .dout(sda_s)
    );

    assign ctrl_wr = reg_wr && (reg_addr == `TWS_ADDR_CONTROL);
    assign flag_clr = ctrl_wr && reg_wdata[`TWS_C_FLAG];
    assign go = en_r && !flag_r;
    // Sequencing stalls when the line clock is still low after release
    assign tick = (qcnt_r == 9'h000);
    assign adv = tick && !((phase_r == 2'h2) && !scl_s);
    // Data bits of the address and of transmitted bytes are checked
    assign tx_bit = (bitcnt_r != `TWS_LAST_BIT) && (addr_next_r || !rx_mode_r);

    // Quarter-bit divider
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            qcnt_r <= 9'h000;
        else if (tick)
            qcnt_r <= 9'(`TWS_QTR_CYC - 1);
        else
            qcnt_r <= qcnt_r - 9'h001;
    end

    // Bus busy tracking from START and STOP seen on the lines
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sda_d_r <= 1'b1;
            busy_r <= 1'b0;
        end
        else
        begin
            sda_d_r <= sda_s;
            if (scl_s && sda_d_r && !sda_s)
                busy_r <= 1'b1;
            else if (scl_s && !sda_d_r && sda_s)
                busy_r <= 1'b0;
        end
    end

    // Software-owned control bits and prescaler field
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ack_en_r <= 1'b0;
            start_r <= 1'b0;
            en_r <= 1'b0;
            ie_r <= 1'b0;
            presc_r <= 2'h0;
        end
        else
        begin
            if (ctrl_wr)
            begin
                ack_en_r <= reg_wdata[`TWS_C_ACK];
                start_r <= reg_wdata[`TWS_C_START];
                en_r <= reg_wdata[`TWS_C_EN];
                ie_r <= reg_wdata[`TWS_C_IE];
            end
            if (reg_wr && (reg_addr == `TWS_ADDR_STATUS))
                presc_r <= reg_wdata[`TWS_S_PRESC_HI:`TWS_S_PRESC_LO];
        end
    end

    // Byte register and write collision
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            byte_r <= 8'hff;
            wcol_r <= 1'b0;
        end
        else if (rx_load_r)
            byte_r <= sh_r;
        else if (reg_wr && (reg_addr == `TWS_ADDR_BYTE))
        begin
            if (flag_r)
            begin
                byte_r <= reg_wdata;
                wcol_r <= 1'b0;
            end
            else
                wcol_r <= 1'b1;
        end
    end

    // Sequencer; also owns the flag, stop command and status code
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= TWS_IDLE;
            phase_r <= 2'h0;
            bitcnt_r <= 4'h0;
            sh_r <= 8'hff;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            flag_r <= 1'b0;
            stop_r <= 1'b0;
            code_r <= `TWS_CODE_IDLE;
            master_r <= 1'b0;
            addr_next_r <= 1'b0;
            rx_mode_r <= 1'b0;
            dir_r <= 1'b0;
            ack_seen_r <= 1'b0;
            rx_load_r <= 1'b0;
        end
        else
        begin
            rx_load_r <= 1'b0;
            // Hardware set beats a software clear in the same cycle
            if (flag_clr)
                flag_r <= 1'b0;
            if (ctrl_wr && reg_wdata[`TWS_C_STOP])
                stop_r <= 1'b1;
            if (!en_r)
            begin
                state_r <= TWS_IDLE;
                scl_oe <= 1'b0;
                sda_oe <= 1'b0;
                master_r <= 1'b0;
            end
            else
            begin
                case (state_r)
                    TWS_IDLE:
                    begin
                        phase_r <= 2'h0;
                        if (go && start_r)
                            state_r <= TWS_WAIT_FREE;
                    end
                    TWS_WAIT_FREE:
                    begin
                        if (tick && !busy_r)
                            state_r <= TWS_START;
                    end
                    TWS_START:
                    begin
                        if (adv)
                        begin
                            phase_r <= phase_r + 2'h1;
                            if (phase_r == 2'h0 && busy_r)
                                state_r <= TWS_WAIT_FREE;
                            else if (phase_r == 2'h1)
                                sda_oe <= 1'b1;
                            else if (phase_r == 2'h2)
                            begin
                                scl_oe <= 1'b1;
                                state_r <= TWS_HOLD;
                                flag_r <= 1'b1;
                                code_r <= `TWS_CODE_START;
                                master_r <= 1'b1;
                                addr_next_r <= 1'b1;
                            end
                        end
                    end
                    TWS_HOLD:
                    begin
                        phase_r <= 2'h0;
                        bitcnt_r <= 4'h0;
                        if (go)
                        begin
                            if (stop_r)
                                state_r <= TWS_STOP;
                            else if (start_r)
                                state_r <= TWS_RSTART;
                            else
                            begin
                                state_r <= TWS_BIT;
                                sh_r <= byte_r;
                                if (addr_next_r)
                                    dir_r <= byte_r[0];
                            end
                        end
                    end
                    TWS_RSTART:
                    begin
                        if (adv)
                        begin
                            phase_r <= phase_r + 2'h1;
                            case (phase_r)
                                2'h0: sda_oe <= 1'b0;
                                2'h1: scl_oe <= 1'b0;
                                2'h2: sda_oe <= 1'b1;
                                default:
                                begin
                                    scl_oe <= 1'b1;
                                    state_r <= TWS_HOLD;
                                    flag_r <= 1'b1;
                                    code_r <= `TWS_CODE_RSTART;
                                    addr_next_r <= 1'b1;
                                end
                            endcase
                        end
                    end
                    TWS_BIT:
                    begin
                        if (adv)
                        begin
                            phase_r <= phase_r + 2'h1;
                            case (phase_r)
                                2'h0:
                                begin
                                    // Low on the line means a zero bit
                                    if (bitcnt_r != `TWS_LAST_BIT)
                                        sda_oe <= tx_bit && !sh_r[7];
                                    else
                                        sda_oe <= !addr_next_r && rx_mode_r
                                            && ack_en_r;
                                end
                                2'h1: scl_oe <= 1'b0;
                                2'h2:
                                begin
                                    if (tx_bit && !sda_oe && !sda_s)
                                    begin
                                        // Lost: release both lines
                                        state_r <= TWS_IDLE;
                                        sda_oe <= 1'b0;
                                        master_r <= 1'b0;
                                        flag_r <= 1'b1;
                                        code_r <= `TWS_CODE_LOST;
                                    end
                                    else if (bitcnt_r != `TWS_LAST_BIT)
                                        sh_r <= {sh_r[6:0], sda_s};
                                    else
                                        ack_seen_r <= !sda_s;
                                end
                                default:
                                begin
                                    scl_oe <= 1'b1;
                                    if (bitcnt_r != `TWS_LAST_BIT)
                                        bitcnt_r <= bitcnt_r + 4'h1;
                                    else
                                    begin
                                        state_r <= TWS_HOLD;
                                        sda_oe <= 1'b0;
                                        flag_r <= 1'b1;
                                        addr_next_r <= 1'b0;
                                        if (addr_next_r)
                                        begin
                                            rx_mode_r <= dir_r;
                                            if (dir_r)
                                                code_r <= ack_seen_r ?
                                                    `TWS_CODE_AR_ACK :
                                                    `TWS_CODE_AR_NACK;
                                            else
                                                code_r <= ack_seen_r ?
                                                    `TWS_CODE_AW_ACK :
                                                    `TWS_CODE_AW_NACK;
                                        end
                                        else if (rx_mode_r)
                                        begin
                                            rx_load_r <= 1'b1;
                                            code_r <= ack_en_r ?
                                                `TWS_CODE_RD_ACK :
                                                `TWS_CODE_RD_NACK;
                                        end
                                        else
                                            code_r <= ack_seen_r ?
                                                `TWS_CODE_D_ACK :
                                                `TWS_CODE_D_NACK;
                                    end
                                end
                            endcase
                        end
                    end
                    TWS_STOP:
                    begin
                        if (adv)
                        begin
                            phase_r <= phase_r + 2'h1;
                            case (phase_r)
                                2'h0: sda_oe <= 1'b1;
                                2'h1: scl_oe <= 1'b0;
                                2'h2:
                                begin
                                    // A pending start follows via idle
                                    sda_oe <= 1'b0;
                                    state_r <= TWS_IDLE;
                                    stop_r <= 1'b0;
                                    master_r <= 1'b0;
                                    code_r <= `TWS_CODE_IDLE;
                                end
                                default: phase_r <= 2'h0;
                            endcase
                        end
                    end
                    default: state_r <= TWS_IDLE;
                endcase
            end
        end
    end

    // Open-drain levels and the interrupt request
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            irq <= flag_r && ie_r;
        end
    end

    // Read port, data valid the cycle after the strobe
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            if (reg_addr == `TWS_ADDR_CONTROL)
                reg_rdata <= {flag_r, ack_en_r, start_r, stop_r,
                              wcol_r, en_r, 1'b0, ie_r};
            else if (reg_addr == `TWS_ADDR_STATUS)
                reg_rdata <= {code_r[`TWS_S_CODE_HI:`TWS_S_CODE_LO],
                              1'b0, presc_r};
            else if (reg_addr == `TWS_ADDR_BYTE)
                reg_rdata <= byte_r;
            else
                reg_rdata <= 8'h00;
        end
    end

endmodule : tws_master

// [testbench/tws_master_props.sv]
/*
 * Port assertions for tws_master.
 * Assumes one clock domain and the interrupt enable set by the bench.
 */
`timescale 1ns/10ps
module tws_master_props
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register port
    input wire tws_pkg::tws_addr_t reg_addr,
    input wire tws_pkg::tws_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire tws_pkg::tws_byte_t reg_rdata,
    // Lines and request
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic irq
);
    import tws_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_start;
        $rose(sda_oe) && !scl_oe;
    endsequence
    sequence s_clear;
        reg_wr && reg_addr == 2'h0 && reg_wdata[7];
    endsequence

    a_start_clk_low: assert property (s_start |-> ##[1:300] scl_oe)
        else $error("clock not pulled after start");
    a_flag_clear: assert property (s_clear |-> ##2 !irq)
        else $error("request stays after flag clear");
    a_irq_masked: assert property
        (reg_wr && reg_addr == 2'h0 && !reg_wdata[0] |-> ##2 !irq)
        else $error("request while disabled");
    // A held flag must freeze both lines
    a_bus_held: assert property
        (irq && $past(irq) && !$past(reg_wr) && !reg_wr && scl_oe
        |=> scl_oe && $stable(sda_oe))
        else $error("bus moved while flag set");
    a_open_drain: assert property (!scl_out && !sda_out)
        else $error("line driven high");
    a_unmapped_zero: assert property
        (reg_rd && reg_addr == 2'h3 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_keep: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without read");
    a_status_gap: assert property
        (reg_rd && reg_addr == 2'h1 |=> !reg_rdata[2])
        else $error("status bit 2 set");
    a_ctl_unused: assert property
        (reg_rd && reg_addr == 2'h0 |=> !reg_rdata[1])
        else $error("control bit 1 set");
endmodule : tws_master_props

bind tws_master tws_master_props tws_master_props_i
(
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scl_in(scl_in), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .irq(irq)
);

// [testbench/tws_slave_model.sv]
/*
 * Slave receiver on the two-wire bus: acks each byte unless told not
 * to, and can hold the data line low to win arbitration.
 * Assumes resolved open-drain levels with pull-ups on both lines.
 */
`timescale 1ns/10ps
module tws_slave_model
(
    // Bus lines
    input wire logic scl,
    input wire logic sda,
    // Commands from the bench
    input wire logic nack,
    input wire logic fight,
    // Drive and observation
    output logic sda_pull,
    output logic [7:0] rx_byte
);
    logic [3:0] bit_cnt;
    logic [7:0] shift_r;
    logic ack_r;

    initial
    begin
        bit_cnt = 4'h0;
        shift_r = 8'h00;
        ack_r = 1'b0;
        rx_byte = 8'h00;
    end

    assign sda_pull = ack_r | fight;

    // START and repeated START restart framing
    always @(negedge sda)
        if (scl)
            bit_cnt = 4'h0;

    always @(posedge scl)
        if (bit_cnt < 4'h8)
        begin
            shift_r = {shift_r[6:0], sda};
            bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == 4'h8)
                rx_byte = shift_r;
        end

    // Ack stands from the 8th falling clock to the 9th
    always @(negedge scl)
        if (bit_cnt == 4'h8)
        begin
            ack_r = !nack;
            bit_cnt = 4'h9;
        end
        else if (bit_cnt == 4'h9)
        begin
            ack_r = 1'b0;
            bit_cnt = 4'h0;
        end
endmodule : tws_slave_model

// [testbench/tws_master_tb.sv]
/*
 * Self-checking bench for tws_master against a slave model.
 * Assumes the register indices and status codes of the header.
 */
`timescale 1ns/10ps
`include "tws_regs.svh"
module tws_master_tb;
    import tws_pkg::*;
    logic sys_clk;
    logic reset_n;
    tws_addr_t reg_addr;
    tws_byte_t reg_wdata;
    tws_byte_t reg_rdata;
    logic reg_wr;
    logic reg_rd;
    logic scl_out;
    logic scl_oe;
    logic sda_out;
    logic sda_oe;
    logic irq;
    logic sda_pull;
    logic nack;
    logic fight;
    tws_byte_t rx_byte;
    tws_byte_t target_address;
    wire logic scl_line = ~scl_oe;
    wire logic sda_line = ~(sda_oe | sda_pull);
    int err_total;
    int check_count;
    int seed;

    tws_master tws_master_i
    (
        .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .scl_in(scl_line), .scl_out(scl_out),
        .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .irq(irq)
    );
    tws_slave_model tws_slave_model_i
    (
        .scl(scl_line), .sda(sda_line), .nack(nack), .fight(fight),
        .sda_pull(sda_pull), .rx_byte(rx_byte)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    function automatic tws_byte_t exp_data(input logic nk);
        return nk ? `TWS_CODE_D_NACK : `TWS_CODE_D_ACK;
    endfunction : exp_data

    task automatic chk(input tws_byte_t got, input tws_byte_t exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // A gap cycle after each strobe keeps one assignment per time step
    task automatic wr(input tws_addr_t a, input tws_byte_t d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : wr

    task automatic rchk(input tws_addr_t a, input tws_byte_t m,
        input tws_byte_t exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        chk(reg_rdata & m, exp);
    endtask : rchk

    task automatic cmd(input tws_byte_t ctl, input tws_byte_t code);
        int n;
        n = 0;
        wr(`TWS_ADDR_CONTROL, ctl);
        repeat (3) @(posedge sys_clk);
        while (irq !== 1'b1 && n < 20000)
        begin
            @(posedge sys_clk);
            n++;
        end
        chk({7'h0, irq}, 8'h01);
        rchk(`TWS_ADDR_STATUS, 8'hf8, code);
    endtask : cmd

    task automatic xfer(input tws_byte_t b, input tws_byte_t code);
        wr(`TWS_ADDR_BYTE, b);
        cmd(8'h85, code);
        if (code != `TWS_CODE_LOST)
            chk(rx_byte, b);
    endtask : xfer

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test

    initial
    begin
        repeat (90000) @(posedge sys_clk);
        err_total++;
        finish_test();
    end

    initial
    begin
        seed = 32'h74b7f32a;
        err_total = 0;
        check_count = 0;
        reset_n = 1'b0;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        nack = 1'b0;
        fight = 1'b0;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        rchk(`TWS_ADDR_CONTROL, 8'hff, 8'h00);
        rchk(`TWS_ADDR_STATUS, 8'hff, `TWS_CODE_IDLE);
        rchk(`TWS_ADDR_BYTE, 8'hff, 8'hff);
        rchk(2'h3, 8'hff, 8'h00);
        wr(`TWS_ADDR_BYTE, 8'h5a);
        rchk(`TWS_ADDR_CONTROL, 8'h08, 8'h08);
        rchk(`TWS_ADDR_BYTE, 8'hff, 8'hff);
        $display("test registers done");
        target_address = 8'($random(seed)) & 8'hfe;
        cmd(8'ha5, `TWS_CODE_START);
        xfer(target_address, `TWS_CODE_AW_ACK);
        for (int i = 0; i < 2; i++)
        begin
            nack <= i[0];
            xfer(8'($random(seed)), exp_data(i[0]));
        end
        nack <= 1'b0;
        cmd(8'hb5, `TWS_CODE_START);
        rchk(`TWS_ADDR_CONTROL, 8'h10, 8'h00);
        $display("test write done");
        fight <= 1'b1;
        xfer(8'hfe, `TWS_CODE_LOST);
        chk({6'h0, scl_oe, sda_oe}, 8'h00);
        fight <= 1'b0;
        cmd(8'ha5, `TWS_CODE_START);
        nack <= 1'b1;
        xfer(target_address, `TWS_CODE_AW_NACK);
        nack <= 1'b0;
        cmd(8'ha5, `TWS_CODE_RSTART);
        xfer(target_address | 8'h01, `TWS_CODE_AR_ACK);
        wr(`TWS_ADDR_CONTROL, 8'h04);
        rchk(`TWS_ADDR_CONTROL, 8'h80, 8'h80);
        chk({7'h0, irq}, 8'h00);
        $display("test arbitration done");
        // Nobody drives the data line, so the received byte is all ones
        nack <= 1'b1;
        cmd(8'h85, `TWS_CODE_RD_NACK);
        rchk(`TWS_ADDR_BYTE, 8'hff, 8'hff);
        nack <= 1'b0;
        // Plain STOP sets no flag, so wait a fixed span instead of irq
        wr(`TWS_ADDR_CONTROL, 8'h94);
        repeat (1200) @(posedge sys_clk);
        rchk(`TWS_ADDR_STATUS, 8'hf8, `TWS_CODE_IDLE);
        rchk(`TWS_ADDR_CONTROL, 8'h90, 8'h00);
        chk({6'h0, scl_oe, sda_oe}, 8'h00);
        $display("test stop done");
        finish_test();
    end
endmodule : tws_master_tb
